// >>> logic/record_file_update_search.sv
// record update and record search command engine with an ahb-lite register port
`timescale 1ns/1ps
// Summary of operation
// R1: update only runs when the file's update access is granted
// R2: a failed update leaves the record pointer exactly as before
// R3: cyclic files accept only the previous mode for updates
// R4: current mode writes the pointed record, pointer unchanged
// R5: absolute mode writes the record numbered in p1, pointer unchanged
// R6: next mode advances pointer then writes; unset pointer goes to record one
// R7: next on linear file at last record writes nothing, pointer kept
// R8: previous on linear steps pointer back then writes; unset goes to last
// R9: previous on linear file at first record writes nothing, pointer kept
// R10: cyclic update writes oldest record, points to it, it becomes number one
// R11: update carries record number in p1, mode in p2, length lc, no le
// R12: mode low bits pick next, previous, absolute/current; high bits pick file
// R13: terminal sends zero p1 for next and previous updates
// R14: search only runs when the file's read access is granted
// R15: return matching record numbers in search order, at most le of them
// R16: empty answer when le is absent or nothing matches
// R17: on any match the pointer goes to the first matching record
// R18: search p1 gives the start record, zero meaning current record
// R19: search mode low bits pick simple, enhanced or proprietary; high bits file
// R20: enhanced data starts with two indication bytes then the pattern
// R21: indication start field picks absolute offset or after first byte value
// R22: indication low bits pick direction and start record
// R23: terminal sends zero p1 for next and previous enhanced searches
// R24: reserved mode or indication codes are rejected with nothing changed
// R25: update data length must equal the record length
module record_file_update_search (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    rec_cmd_pkg::ctl_state_e state_reg;
    logic [31:0] cmd_reg;
    logic [31:0] cfg_reg;
    logic [31:0] data_reg;
    logic [31:0] res_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] rec_mem [8];
    logic [3:0]  ptr_reg;
    logic        ptr_valid_reg;
    logic [2:0]  newest_reg;
    logic [3:0]  cur_reg;
    logic [3:0]  cnt_reg;
    logic        found_reg;
    logic        ok_reg;
    logic        rej_reg;
    logic        nowr_reg;
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;

    // ------------------------------------------------------------
    // command field decode
    // ------------------------------------------------------------
    wire [7:0] p1        = cmd_reg[rec_cmd_pkg::CMD_P1 +: 8];
    wire [7:0] p2        = cmd_reg[rec_cmd_pkg::CMD_P2 +: 8];
    wire [7:0] lc        = cmd_reg[rec_cmd_pkg::CMD_LC +: 8];              // [R11]
    wire [3:0] le        = cmd_reg[rec_cmd_pkg::CMD_LE +: 4];
    wire       op_search = cmd_reg[rec_cmd_pkg::CMD_SEARCH];
    wire [2:0] mode      = p2[2:0];
    wire [4:0] short_file_id = p2[7:3];
    wire       cyclic    = cfg_reg[rec_cmd_pkg::CFG_CYCLIC];
    wire       upd_ok    = cfg_reg[rec_cmd_pkg::CFG_UPD_OK];
    wire       rd_ok     = cfg_reg[rec_cmd_pkg::CFG_RD_OK];
    wire       busy      = (state_reg != rec_cmd_pkg::ST_IDLE);
    wire       exec_upd  = (state_reg == rec_cmd_pkg::ST_EXEC) && !op_search;
    wire       exec_srch = (state_reg == rec_cmd_pkg::ST_EXEC) && op_search;
    wire       p1_zero   = (p1 == 8'h00);
    wire       p1_big    = (p1 > {4'h0, rec_cmd_pkg::LAST_REC});
    wire       sfi_bad   = (short_file_id == rec_cmd_pkg::SFI_RESVD);
    wire [3:0] ptr_inc   = ptr_reg + 4'h1;
    wire [3:0] ptr_dec   = ptr_reg - 4'h1;

    // logical record number to memory slot; cyclic files rotate from the newest
    function automatic logic [2:0] phys_of(input logic [3:0] l);
        return cyclic ? 3'(newest_reg + l[2:0] - 3'h1) : 3'(l[2:0] - 3'h1);
    endfunction

    // ------------------------------------------------------------
    // update decision
    // ------------------------------------------------------------
    wire is_abs_md = (mode == rec_cmd_pkg::MODE_ABS);
    wire is_cur    = is_abs_md && p1_zero;
    wire is_abs    = is_abs_md && !p1_zero;
    wire is_next   = (mode == rec_cmd_pkg::MODE_NEXT);
    wire is_prev   = (mode == rec_cmd_pkg::MODE_PREV);
    wire upd_reject = !upd_ok                                         // [R1]
                    || sfi_bad                                        // [R12]
                    || !(is_next || is_prev || is_abs_md)             // [R24]
                    || (lc != rec_cmd_pkg::REC_BYTES)                 // [R25]
                    || (cyclic && !is_prev)                           // [R3]
                    || (is_abs && p1_big)
                    || (is_cur && !ptr_valid_reg);
    wire upd_edge = !cyclic && ptr_valid_reg                          // [R7] [R9]
                  && ((is_next && ptr_reg == rec_cmd_pkg::LAST_REC)
                   || (is_prev && ptr_reg == rec_cmd_pkg::FIRST_REC));
    wire [3:0] upd_target = is_cur  ? ptr_reg :                       // [R4]
                            is_abs  ? p1[3:0] :                       // [R5]
                            is_next ? (ptr_valid_reg ? ptr_inc : rec_cmd_pkg::FIRST_REC) :
                                      (ptr_valid_reg ? ptr_dec : rec_cmd_pkg::LAST_REC);
    wire [2:0] oldest  = newest_reg - 3'h1;
    wire [2:0] wr_phys = cyclic ? oldest : phys_of(upd_target);        // [R10]
    wire       mem_we  = exec_upd && !upd_reject && !upd_edge;
    wire       ptr_moves = is_next || is_prev;                        // [R6] [R8]

    // ------------------------------------------------------------
    // search decision
    // ------------------------------------------------------------
    wire       enh     = (mode == rec_cmd_pkg::SRCH_ENH);
    wire [7:0] ind1    = data_reg[rec_cmd_pkg::DAT_IND1 +: 8];         // [R20]
    wire [7:0] ind2    = data_reg[rec_cmd_pkg::DAT_IND2 +: 8];
    wire [7:0] pattern = enh ? data_reg[rec_cmd_pkg::DAT_ENHPAT +: 8]
                             : data_reg[rec_cmd_pkg::DAT_PAT +: 8];
    wire [2:0] sel_dir = enh ? ind1[2:0] : mode;                      // [R22]
    wire       ind_bad = enh && (!ind1[2] || (ind1[7:3] != rec_cmd_pkg::START_OFF
                                           && ind1[7:3] != rec_cmd_pkg::START_AFT));
    wire srch_reject = !rd_ok                                         // [R14]
                     || sfi_bad || !mode[2]                           // [R19]
                     || (mode == rec_cmd_pkg::SRCH_PROP)
                     || ind_bad                                       // [R24]
                     || p1_big;
    wire       back    = sel_dir[0];
    wire       from_nb = enh && sel_dir[1];
    wire [3:0] edge_rec = back ? rec_cmd_pkg::LAST_REC : rec_cmd_pkg::FIRST_REC;
    wire [3:0] home     = ptr_valid_reg ? ptr_reg : edge_rec;
    wire [3:0] nb_rec   = ptr_valid_reg ? (back ? ptr_dec : ptr_inc) : edge_rec;
    wire [3:0] s_start  = from_nb ? nb_rec : (p1_zero ? home : p1[3:0]); // [R18] [R23]
    wire       in_range = (cur_reg != 4'h0) && (cur_reg <= rec_cmd_pkg::LAST_REC);
    wire [31:0] cur_word = rec_mem[phys_of(cur_reg)];
    wire        start_after = enh && (ind1[7:3] == rec_cmd_pkg::START_AFT);
    wire [7:0]  start_off   = enh ? ind2 : 8'h00;
    wire        take = (cnt_reg < le);                                // [R15] [R16]

    logic       hit;
    logic       seen;
    logic [7:0] rec_byte;
    always_comb begin
        hit      = 1'b0;
        seen     = 1'b0;
        rec_byte = 8'h00;
        for (int j = 0; j < rec_cmd_pkg::REC_BYTE_N; j++) begin
            rec_byte = cur_word[8*j +: 8];
            if (start_after) begin                                    // [R21]
                if (seen && rec_byte == pattern) hit = 1'b1;
                if (rec_byte == ind2) seen = 1'b1;
            end else if (8'(j) >= start_off && rec_byte == pattern) begin
                hit = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    wire ap_valid = hsel && htrans[1] && hready;
    wire wr_hit_cmd  = wr_pend_reg && (wr_addr_reg == rec_cmd_pkg::ADDR_CMD) && !busy;
    wire wr_hit_cfg  = wr_pend_reg && (wr_addr_reg == rec_cmd_pkg::ADDR_CFG);
    wire wr_hit_data = wr_pend_reg && (wr_addr_reg == rec_cmd_pkg::ADDR_DATA);
    wire wr_hit_rec  = wr_pend_reg && (wr_addr_reg[7:5] == rec_cmd_pkg::REC_WIN_TAG)
                       && !busy;
    wire [31:0] status_word = {16'h0000, cnt_reg, newest_reg, ptr_valid_reg, ptr_reg,
                               nowr_reg, rej_reg, ok_reg, busy};
    wire [7:0]  ra = haddr[7:0];
    wire [31:0] rd_mux =
        (ra == rec_cmd_pkg::ADDR_CMD)    ? cmd_reg :
        (ra == rec_cmd_pkg::ADDR_CFG)    ? cfg_reg :
        (ra == rec_cmd_pkg::ADDR_DATA)   ? data_reg :
        (ra == rec_cmd_pkg::ADDR_STATUS) ? status_word :
        (ra == rec_cmd_pkg::ADDR_RESULT) ? res_reg :
        (ra[7:5] == rec_cmd_pkg::REC_WIN_TAG) ? rec_mem[ra[4:2]] : 32'h0000_0000;

    assign hrdata    = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata_reg  <= 32'h0000_0000;
        end else begin
            wr_pend_reg <= ap_valid && hwrite;
            if (ap_valid) wr_addr_reg <= haddr[7:0];
            if (ap_valid && !hwrite) hrdata_reg <= rd_mux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_reg  <= rec_cmd_pkg::CFG_RESET;
            data_reg <= 32'h0000_0000;
        end else begin
            if (wr_hit_cfg) cfg_reg <= hwdata;
            if (wr_hit_data) data_reg <= hwdata;
        end
    end

    // ------------------------------------------------------------
    // record store
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 8; i++) rec_mem[i] <= 32'h0000_0000;
        end else if (mem_we) begin
            rec_mem[wr_phys] <= data_reg;                             // [R1] [R25]
        end else if (wr_hit_rec) begin
            rec_mem[wr_addr_reg[4:2]] <= hwdata;
        end
    end

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg     <= rec_cmd_pkg::ST_IDLE;
            cmd_reg       <= rec_cmd_pkg::CMD_RESET;
            res_reg       <= 32'h0000_0000;
            ptr_reg       <= 4'h0;
            ptr_valid_reg <= 1'b0;
            newest_reg    <= 3'h0;
            cur_reg       <= 4'h0;
            cnt_reg       <= 4'h0;
            found_reg     <= 1'b0;
            ok_reg        <= 1'b0;
            rej_reg       <= 1'b0;
            nowr_reg      <= 1'b0;
        end else begin
            unique case (state_reg)
                rec_cmd_pkg::ST_IDLE: begin
                    if (wr_hit_cmd) begin
                        cmd_reg   <= hwdata;
                        state_reg <= rec_cmd_pkg::ST_EXEC;
                        ok_reg    <= 1'b0;
                        rej_reg   <= 1'b0;
                        nowr_reg  <= 1'b0;
                    end
                end
                rec_cmd_pkg::ST_EXEC: begin
                    if (!op_search) begin
                        state_reg <= rec_cmd_pkg::ST_IDLE;
                        rej_reg   <= upd_reject;                      // [R2]
                        nowr_reg  <= !upd_reject && upd_edge;
                        ok_reg    <= mem_we;
                        if (mem_we && cyclic) begin                   // [R10]
                            newest_reg    <= oldest;
                            ptr_reg       <= rec_cmd_pkg::FIRST_REC;
                            ptr_valid_reg <= 1'b1;
                        end else if (mem_we && ptr_moves) begin       // [R6] [R8]
                            ptr_reg       <= upd_target;
                            ptr_valid_reg <= 1'b1;
                        end
                    end else if (srch_reject) begin
                        state_reg <= rec_cmd_pkg::ST_IDLE;            // [R14] [R24]
                        rej_reg   <= 1'b1;
                    end else begin
                        state_reg <= rec_cmd_pkg::ST_SEARCH;
                        cur_reg   <= s_start;
                        cnt_reg   <= 4'h0;
                        res_reg   <= 32'h0000_0000;
                        found_reg <= 1'b0;
                    end
                end
                rec_cmd_pkg::ST_SEARCH: begin
                    if (in_range) begin
                        cur_reg <= back ? cur_reg - 4'h1 : cur_reg + 4'h1;
                        if (hit && !found_reg) begin                  // [R17]
                            ptr_reg       <= cur_reg;
                            ptr_valid_reg <= 1'b1;
                            found_reg     <= 1'b1;
                        end
                        if (hit && take) begin                        // [R15] [R16]
                            res_reg[{cnt_reg[2:0], 2'b00} +: 4] <= cur_reg;
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                    end else begin
                        state_reg <= rec_cmd_pkg::ST_IDLE;
                        ok_reg    <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_upd_access;
        exec_upd && !upd_ok |-> !mem_we ##1 (!busy && rej_reg);
    endproperty
    a_upd_access: assert property (p_upd_access) else $error("update ran without access"); // [R1]

    property p_fail_ptr;
        exec_upd && (upd_reject || upd_edge) |=> $stable(ptr_reg) && $stable(ptr_valid_reg);
    endproperty
    a_fail_ptr: assert property (p_fail_ptr) else $error("failed update moved pointer"); // [R2]

    property p_cyc_mode;
        exec_upd && cyclic && !is_prev |=> rej_reg && !ok_reg;
    endproperty
    a_cyc_mode: assert property (p_cyc_mode) else $error("cyclic update in bad mode"); // [R3]

    property p_cur;
        mem_we && is_cur |-> (wr_phys == phys_of(ptr_reg)) ##1 $stable(ptr_reg);
    endproperty
    a_cur: assert property (p_cur) else $error("current update wrong target"); // [R4]

    property p_abs;
        mem_we && is_abs |-> (wr_phys == 3'(p1[2:0] - 3'h1)) ##1 $stable(ptr_reg);
    endproperty
    a_abs: assert property (p_abs) else $error("absolute update wrong target"); // [R5]

    property p_next_first;
        exec_upd && is_next && !ptr_valid_reg && !upd_reject |=> ptr_reg == 4'h1 && ok_reg;
    endproperty
    a_next_first: assert property (p_next_first) else $error("next did not go to first"); // [R6]

    property p_next_last;
        exec_upd && is_next && !cyclic && ptr_valid_reg && ptr_reg == 4'h8
            |-> !mem_we ##1 (ptr_reg == 4'h8 && !ok_reg);
    endproperty
    a_next_last: assert property (p_next_last) else $error("next past last record"); // [R7]

    property p_prev_last;
        exec_upd && is_prev && !cyclic && !ptr_valid_reg && !upd_reject |=> ptr_reg == 4'h8;
    endproperty
    a_prev_last: assert property (p_prev_last) else $error("previous did not go to last"); // [R8]

    property p_prev_first;
        exec_upd && is_prev && !cyclic && ptr_valid_reg && ptr_reg == 4'h1
            |-> !mem_we ##1 ptr_reg == 4'h1;
    endproperty
    a_prev_first: assert property (p_prev_first) else $error("previous before first"); // [R9]

    property p_cyclic;
        mem_we && cyclic |=> ptr_reg == 4'h1 && newest_reg == 3'($past(newest_reg) - 3'h1);
    endproperty
    a_cyclic: assert property (p_cyclic) else $error("cyclic update not renumbered"); // [R10]

    property p_read_access;
        exec_srch && !rd_ok |=> !busy && rej_reg && cnt_reg == $past(cnt_reg);
    endproperty
    a_read_access: assert property (p_read_access) else $error("search without access"); // [R14]

    property p_le_cap;
        state_reg == rec_cmd_pkg::ST_SEARCH |-> cnt_reg <= le;
    endproperty
    a_le_cap: assert property (p_le_cap) else $error("too many record numbers"); // [R15] [R16]

    property p_first_hit;
        state_reg == rec_cmd_pkg::ST_SEARCH && in_range && hit && !found_reg
            |=> ptr_reg == $past(cur_reg) && ptr_valid_reg;
    endproperty
    a_first_hit: assert property (p_first_hit) else $error("pointer not on first match"); // [R17]

    property p_reserved;
        exec_upd && !(is_next || is_prev || is_abs_md) |-> !mem_we ##1 rej_reg;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved mode accepted"); // [R24]

    property p_len;
        exec_upd && lc != rec_cmd_pkg::REC_BYTES |-> !mem_we;
    endproperty
    a_len: assert property (p_len) else $error("wrong length written"); // [R25]

    c_update: cover property (mem_we && !cyclic ##1 ok_reg);
    c_cyc_update: cover property (mem_we && cyclic);
    c_search_hit: cover property (state_reg == rec_cmd_pkg::ST_SEARCH && hit && take);
endmodule

// >>> pkg/rec_cmd_pkg.sv
// constants, register map and state type for the record command block
package rec_cmd_pkg;
    // file geometry
    localparam int         REC_BYTE_N = 4;
    localparam logic [7:0] REC_BYTES  = 8'h04;
    localparam logic [3:0] FIRST_REC  = 4'h1;
    localparam logic [3:0] LAST_REC   = 4'h8;

    // register byte offsets, decoded on haddr[7:0]
    localparam logic [7:0] ADDR_CMD    = 8'h00;
    localparam logic [7:0] ADDR_CFG    = 8'h04;
    localparam logic [7:0] ADDR_DATA   = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_RESULT = 8'h10;
    localparam logic [2:0] REC_WIN_TAG = 3'h1;

    // field positions
    localparam int CMD_P1     = 0;
    localparam int CMD_P2     = 8;
    localparam int CMD_LC     = 16;
    localparam int CMD_LE     = 24;
    localparam int CMD_SEARCH = 28;
    localparam int CFG_CYCLIC = 0;
    localparam int CFG_UPD_OK = 1;
    localparam int CFG_RD_OK  = 2;
    localparam int DAT_IND1   = 0;
    localparam int DAT_IND2   = 8;
    localparam int DAT_ENHPAT = 16;
    localparam int DAT_PAT    = 0;

    // reset values
    localparam logic [31:0] CMD_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // mode, reserved file id and indication start codes
    localparam logic [2:0] MODE_NEXT = 3'h2;
    localparam logic [2:0] MODE_PREV = 3'h3;
    localparam logic [2:0] MODE_ABS  = 3'h4;
    localparam logic [2:0] SRCH_ENH  = 3'h6;
    localparam logic [2:0] SRCH_PROP = 3'h7;
    localparam logic [4:0] SFI_RESVD = 5'h1f;
    localparam logic [4:0] START_OFF = 5'h00;
    localparam logic [4:0] START_AFT = 5'h01;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SEARCH} ctl_state_e;
endpackage

// >>> bench/terminal_model.sv
// terminal model: ahb-lite master making single word transfers into the block
`timescale 1ns/1ps
module terminal_model (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata,
    output logic             timed_out
);
    initial begin
        {hsel, haddr, htrans, hwrite, hsize, hwdata, timed_out} = '0;
    end

    task automatic hold();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (hready !== 1'b1) timed_out = 1'b1;
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize  <= 3'b010;
        hold();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= w ? wd : ~hwdata;
        hold();
        rd = hrdata;
        // released data lines must not keep the last value
        hwdata <= ~hwdata;
    endtask
endmodule

// >>> bench/test_record_file_update_search.sv
// self-checking bench: record update and search through the register port
`timescale 1ns/1ps
module test_record_file_update_search;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel, hwrite, hreadyout, hresp, timed_out;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          mismatches = 0;
    int          n_tests = 0;

    always #2.5 hclk = ~hclk;

    record_file_update_search record_file_update_search_inst (.hclk, .hresetn, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
        .hreadyout, .hresp);
    terminal_model terminal_model_inst (.hclk, .hready(hreadyout), .hrdata, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .timed_out);

    task automatic conclude();
        $display("compares %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        terminal_model_inst.xfer(w, a, wd, rd);
        if (timed_out === 1'b1) begin
            mismatches++;
            conclude();
        end
    endtask

    task automatic peek(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        check(r & m, exp);
        check({31'h0, hresp}, 32'h0);
    endtask

    function automatic logic [13:0] sx(input logic [3:0] c, input logic [2:0] w,
        input logic v, input logic [3:0] p, input logic nw, input logic rj);
        return {c, w, v, p, nw, rj};
    endfunction

    // ------------------------------------------------------------
    // one command: data word, command word, poll busy, check status
    // ------------------------------------------------------------
    task automatic run(input logic s, input logic [7:0] p2, input logic [7:0] p1,
        input logic [7:0] lc, input logic [3:0] le, input logic [31:0] d,
        input logic [13:0] exp);
        logic [31:0] st;
        int          n;
        xfer(1'b1, 8'h08, d, st);
        xfer(1'b1, 8'h00, {3'b000, s, le, lc, p2, p1}, st);
        n = 0;
        do begin
            xfer(1'b0, 8'h0c, 32'h0, st);
            n++;
        end while (st[0] !== 1'b0 && n < 40);
        if (st[0] !== 1'b0) begin
            mismatches++;
            conclude();
        end
        check({18'h0, st[15:2]}, {18'h0, exp});
        check({31'h0, st[1]}, {31'h0, ~(exp[1] | exp[0])});
        $display("test %0d done", n_tests);
    endtask

    initial begin
        logic [31:0] r;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        peek(8'h04, 32'hffffffff, 32'h0);
        peek(8'h0c, 32'hffffffff, 32'h0);
        run(0, 8'h02, 0, 4, 0, 32'h0badf00d, sx(0, 0, 0, 0, 0, 1));
        peek(8'h20, 32'hffffffff, 32'h0);
        xfer(1'b1, 8'h04, 32'h6, r);
        run(0, 8'h03, 0, 4, 0, 32'h11223308, sx(0, 0, 1, 8, 0, 0));
        run(0, 8'h02, 0, 4, 0, 32'hdeadbeef, sx(0, 0, 1, 8, 1, 0));
        peek(8'h3c, 32'hffffffff, 32'h11223308);
        run(0, 8'h04, 1, 4, 0, 32'h11223301, sx(0, 0, 1, 8, 0, 0));
        run(0, 8'h04, 0, 4, 0, 32'h44556608, sx(0, 0, 1, 8, 0, 0));
        peek(8'h20, 32'hffffffff, 32'h11223301);
        peek(8'h3c, 32'hffffffff, 32'h44556608);
        run(0, 8'h00, 0, 4, 0, 32'h0, sx(0, 0, 1, 8, 0, 1));
        run(0, 8'hfa, 0, 4, 0, 32'h0, sx(0, 0, 1, 8, 0, 1));
        run(0, 8'h04, 2, 5, 0, 32'h0, sx(0, 0, 1, 8, 0, 1));
        peek(8'h24, 32'hffffffff, 32'h0);
        run(1, 8'h01, 1, 1, 4, 32'h22, sx(0, 0, 1, 8, 0, 1));
        run(1, 8'h04, 1, 1, 4, 32'h22, sx(1, 0, 1, 1, 0, 0));
        peek(8'h10, 32'hf, 32'h1);
        run(1, 8'h04, 1, 1, 4, 32'h77, sx(0, 0, 1, 1, 0, 0));
        run(1, 8'h04, 1, 1, 3, 32'h00, sx(3, 0, 1, 2, 0, 0));
        peek(8'h10, 32'hfff, 32'h432);
        run(1, 8'h05, 8, 1, 2, 32'h00, sx(2, 0, 1, 7, 0, 0));
        peek(8'h10, 32'hff, 32'h67);
        run(1, 8'h06, 1, 3, 1, 32'h00660004, sx(1, 0, 1, 8, 0, 0));
        run(1, 8'h06, 0, 3, 2, 32'h0011330f, sx(1, 0, 1, 1, 0, 0));
        peek(8'h10, 32'hff, 32'h1);
        run(1, 8'h06, 0, 3, 4, 32'h00010006, sx(0, 0, 1, 1, 0, 0));
        run(1, 8'h04, 1, 1, 1, 32'h22, sx(1, 0, 1, 1, 0, 0));
        run(0, 8'h03, 0, 4, 0, 32'hcafe0000, sx(1, 0, 1, 1, 1, 0));
        run(0, 8'h02, 0, 4, 0, 32'h12345602, sx(1, 0, 1, 2, 0, 0));
        peek(8'h24, 32'hffffffff, 32'h12345602);
        xfer(1'b1, 8'h04, 32'h2, r);
        run(1, 8'h04, 1, 1, 4, 32'h22, sx(1, 0, 1, 2, 0, 1));
        xfer(1'b1, 8'h04, 32'h7, r);
        run(0, 8'h02, 0, 4, 0, 32'h0, sx(1, 0, 1, 2, 0, 1));
        run(0, 8'h03, 0, 4, 0, 32'h0c0c0c0c, sx(1, 7, 1, 1, 0, 0));
        peek(8'h3c, 32'hffffffff, 32'h0c0c0c0c);
        conclude();
    end
endmodule
